// ### hw/gss_pkg.sv
package gss_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_THRESH = 8'h04;
   localparam logic [7:0] OFS_TCONST = 8'h08;
   localparam logic [7:0] OFS_BASE_POS = 8'h0c;
   localparam logic [7:0] OFS_ALT_POS = 8'h10;
   localparam logic [7:0] OFS_BASE_SPD = 8'h14;
   localparam logic [7:0] OFS_ALT_SPD = 8'h18;
   localparam logic [7:0] OFS_BASE_INT = 8'h1c;
   localparam logic [7:0] OFS_ALT_INT = 8'h20;
   localparam logic [7:0] OFS_BASE_VIB = 8'h24;
   localparam logic [7:0] OFS_ALT_VIB = 8'h28;
   localparam logic [7:0] OFS_BASE_RES = 8'h2c;
   localparam logic [7:0] OFS_ALT_RES = 8'h30;
   localparam logic [7:0] OFS_BASE_DAMP = 8'h34;
   localparam logic [7:0] OFS_ALT_DAMP = 8'h38;
   localparam logic [7:0] OFS_STATUS = 8'h3c;

   // Mode register field positions
   localparam int ADJ_LSB = 0;
   localparam int TUNE_LSB = 4;
   localparam int SEL_LSB = 8;
   localparam int DIR_BIT = 12;
   // Status register field positions
   localparam int STAT_ACT_BIT = 0;
   localparam int STAT_RATIO_LSB = 8;

   // Mode encodings
   localparam logic [3:0] ADJ_MANUAL = 4'h3;
   localparam logic [3:0] TUNE_MANUAL = 4'h2;
   localparam logic [3:0] SEL_OFF = 4'h0;
   localparam logic [3:0] SEL_INPUT = 4'h1;
   localparam logic [3:0] SEL_LAST = 4'h4;

   // Fallback thresholds in stored units (0.1 rad/s, rad/s, 0.1 ms, 0.1 Hz)
   localparam logic [15:0] POS_MIN = 16'h000a;
   localparam logic [15:0] SPD_MIN = 16'h0014;
   localparam logic [15:0] INT_MIN = 16'h0001;
   localparam logic [15:0] FREQ_MIN = 16'h0001;
   // Upper setting limits in stored units
   localparam logic [15:0] POS_MAX = 16'h4e20;
   localparam logic [15:0] SPD_MAX = 16'hffff;
   localparam logic [15:0] INT_MAX = 16'hc350;
   localparam logic [15:0] FREQ_MAX = 16'h0bb8;
   localparam logic [15:0] DAMP_MAX = 16'h001e;
   localparam logic [15:0] TC_MAX = 16'h0064;

   // Reset values
   localparam logic [15:0] REG_RESET = 16'h0000;

   // Transition ramp: 100 steps of 10 us per ms of time constant
   localparam logic [6:0] RAMP_FULL = 7'h64;
   localparam int STEP_TIME_NS = 10000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CYC_PER_STEP = STEP_TIME_NS / CLK_PERIOD_NS;

   // Applied loop settings
   typedef struct packed {
      logic [15:0] pos_gain;
      logic [15:0] spd_gain;
      logic [15:0] int_comp;
      logic [15:0] vib_freq;
      logic [15:0] res_freq;
      logic [15:0] damping;
   } gss_gains_t;

   // Software settings
   typedef struct packed {
      logic [3:0] adj_mode;
      logic [3:0] tune_mode;
      logic [3:0] sel;
      logic dir;
      logic [15:0] thresh;
      logic [15:0] tconst;
      gss_gains_t base;
      gss_gains_t alt;
   } gss_regs_t;

   // Whole block state
   typedef struct packed {
      gss_regs_t regs;
      logic [1:0] sw_sync;
      logic active;
      logic [6:0] ratio;
      logic [15:0] step_cnt;
      logic [6:0] tc_cnt;
      gss_gains_t applied;
      logic [31:0] rdata;
   } gss_state_t;

   // Alternate value if enabled and not below its floor, else base
   function automatic logic [15:0] gss_pick(input logic [15:0] alt,
      input logic [15:0] base, input logic [15:0] floor, input logic en);
      gss_pick = (en && alt >= floor) ? alt : base;
   endfunction : gss_pick

   // Linear mix of base and alternate by ratio out of RAMP_FULL
   function automatic logic [15:0] gss_blend(input logic [15:0] base,
      input logic [15:0] alt, input logic [6:0] r);
      logic [23:0] acc;
      acc = 24'(base) * 24'(RAMP_FULL - r) + 24'(alt) * 24'(r);
      gss_blend = 16'(acc / 24'(RAMP_FULL));
   endfunction : gss_blend

   // Clip a written value to its upper limit
   function automatic logic [15:0] gss_sat(input logic [31:0] v,
      input logic [15:0] lim);
      gss_sat = (v > 32'(lim)) ? lim : v[15:0];
   endfunction : gss_sat
endpackage : gss_pkg

// ### hw/gss_select.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module gss_select
   import gss_pkg::*;
#(
   parameter int STEP_CYCLES = CYC_PER_STEP
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   // Switching sources
   input wire logic gain_switch_input,
   input wire logic [15:0] monitor_value,
   // Applied loop settings
   output gss_gains_t applied,
   output logic switch_active
);

   localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

   gss_state_t st;
   gss_state_t next_st;
   logic gain_en;
   logic supp_en;
   logic cond_hit;
   logic [6:0] target;
   gss_gains_t tgt;

   // Qualification of the switched sets
   always_comb begin
      gain_en = st.regs.adj_mode == ADJ_MANUAL;
      supp_en = gain_en && st.regs.tune_mode == TUNE_MANUAL
         && st.regs.sel == SEL_INPUT;
      cond_hit = st.regs.dir ? (monitor_value <= st.regs.thresh)
         : (monitor_value >= st.regs.thresh);
      target = st.active ? RAMP_FULL : 7'h00;
   end

   // Switched set after floor substitution
   always_comb begin
      tgt.pos_gain = gss_pick(st.regs.alt.pos_gain, st.regs.base.pos_gain,
         POS_MIN, gain_en);
      tgt.spd_gain = gss_pick(st.regs.alt.spd_gain, st.regs.base.spd_gain,
         SPD_MIN, gain_en);
      tgt.int_comp = gss_pick(st.regs.alt.int_comp, st.regs.base.int_comp,
         INT_MIN, gain_en);
      tgt.vib_freq = gss_pick(st.regs.alt.vib_freq, st.regs.base.vib_freq,
         FREQ_MIN, supp_en);
      tgt.res_freq = gss_pick(st.regs.alt.res_freq, st.regs.base.res_freq,
         FREQ_MIN, supp_en);
      tgt.damping = supp_en ? st.regs.alt.damping
         : st.regs.base.damping;
   end

   // Next state
   always_comb begin
      next_st = st;
      next_st.rdata = 32'h0000_0000;

      // Input pin synchroniser
      next_st.sw_sync = {st.sw_sync[0], gain_switch_input};

      // Switching decision
      case (st.regs.sel)
         SEL_OFF: next_st.active = 1'b0;
         SEL_INPUT: next_st.active = st.sw_sync[1];
         default: next_st.active = (st.regs.sel <= SEL_LAST) && cond_hit;
      endcase

      // Ratio ramp toward the selected set
      if (st.regs.tconst == 16'h0000) begin
         next_st.ratio = target;
         next_st.step_cnt = 16'h0000;
         next_st.tc_cnt = 7'h00;
      end else if (st.ratio == target) begin
         next_st.step_cnt = 16'h0000;
         next_st.tc_cnt = 7'h00;
      end else if (st.step_cnt != STEP_LAST) begin
         next_st.step_cnt = st.step_cnt + 16'h0001;
      end else begin
         next_st.step_cnt = 16'h0000;
         // One ratio step per tconst steps of 10 us
         if (16'(st.tc_cnt) + 16'h0001 >= st.regs.tconst) begin
            next_st.tc_cnt = 7'h00;
            next_st.ratio = (st.ratio < target) ? st.ratio + 7'h01
               : st.ratio - 7'h01;
         end else begin
            next_st.tc_cnt = st.tc_cnt + 7'h01;
         end
      end

      // Mixed outputs; ratio zero gives base exactly
      next_st.applied.pos_gain = gss_blend(st.regs.base.pos_gain,
         tgt.pos_gain, st.ratio);
      next_st.applied.spd_gain = gss_blend(st.regs.base.spd_gain,
         tgt.spd_gain, st.ratio);
      next_st.applied.int_comp = gss_blend(st.regs.base.int_comp,
         tgt.int_comp, st.ratio);
      next_st.applied.vib_freq = gss_blend(st.regs.base.vib_freq,
         tgt.vib_freq, st.ratio);
      next_st.applied.res_freq = gss_blend(st.regs.base.res_freq,
         tgt.res_freq, st.ratio);
      next_st.applied.damping = gss_blend(st.regs.base.damping,
         tgt.damping, st.ratio);

      // Register writes, all but mode and threshold clipped to setting ranges
      if (wr_stb) begin
         case (addr)
            OFS_MODE: begin
               next_st.regs.adj_mode = wdata[ADJ_LSB +: 4];
               next_st.regs.tune_mode = wdata[TUNE_LSB +: 4];
               next_st.regs.sel = wdata[SEL_LSB +: 4];
               next_st.regs.dir = wdata[DIR_BIT];
            end
            OFS_THRESH: next_st.regs.thresh = wdata[15:0];
            OFS_TCONST: next_st.regs.tconst = gss_sat(wdata, TC_MAX);
            OFS_BASE_POS: next_st.regs.base.pos_gain =
               gss_sat(wdata, POS_MAX);
            OFS_ALT_POS: next_st.regs.alt.pos_gain =
               gss_sat(wdata, POS_MAX);
            OFS_BASE_SPD: next_st.regs.base.spd_gain =
               gss_sat(wdata, SPD_MAX);
            OFS_ALT_SPD: next_st.regs.alt.spd_gain =
               gss_sat(wdata, SPD_MAX);
            OFS_BASE_INT: next_st.regs.base.int_comp =
               gss_sat(wdata, INT_MAX);
            OFS_ALT_INT: next_st.regs.alt.int_comp =
               gss_sat(wdata, INT_MAX);
            OFS_BASE_VIB: next_st.regs.base.vib_freq =
               gss_sat(wdata, FREQ_MAX);
            OFS_ALT_VIB: next_st.regs.alt.vib_freq =
               gss_sat(wdata, FREQ_MAX);
            OFS_BASE_RES: next_st.regs.base.res_freq =
               gss_sat(wdata, FREQ_MAX);
            OFS_ALT_RES: next_st.regs.alt.res_freq =
               gss_sat(wdata, FREQ_MAX);
            OFS_BASE_DAMP: next_st.regs.base.damping =
               gss_sat(wdata, DAMP_MAX);
            OFS_ALT_DAMP: next_st.regs.alt.damping =
               gss_sat(wdata, DAMP_MAX);
            default: begin
            end
         endcase
      end

      // Register reads, data one cycle later
      if (rd_stb) begin
         case (addr)
            OFS_MODE: begin
               next_st.rdata[ADJ_LSB +: 4] = st.regs.adj_mode;
               next_st.rdata[TUNE_LSB +: 4] = st.regs.tune_mode;
               next_st.rdata[SEL_LSB +: 4] = st.regs.sel;
               next_st.rdata[DIR_BIT] = st.regs.dir;
            end
            OFS_THRESH: next_st.rdata[15:0] = st.regs.thresh;
            OFS_TCONST: next_st.rdata[15:0] = st.regs.tconst;
            OFS_BASE_POS: next_st.rdata[15:0] = st.regs.base.pos_gain;
            OFS_ALT_POS: next_st.rdata[15:0] = st.regs.alt.pos_gain;
            OFS_BASE_SPD: next_st.rdata[15:0] = st.regs.base.spd_gain;
            OFS_ALT_SPD: next_st.rdata[15:0] = st.regs.alt.spd_gain;
            OFS_BASE_INT: next_st.rdata[15:0] = st.regs.base.int_comp;
            OFS_ALT_INT: next_st.rdata[15:0] = st.regs.alt.int_comp;
            OFS_BASE_VIB: next_st.rdata[15:0] = st.regs.base.vib_freq;
            OFS_ALT_VIB: next_st.rdata[15:0] = st.regs.alt.vib_freq;
            OFS_BASE_RES: next_st.rdata[15:0] = st.regs.base.res_freq;
            OFS_ALT_RES: next_st.rdata[15:0] = st.regs.alt.res_freq;
            OFS_BASE_DAMP: next_st.rdata[15:0] = st.regs.base.damping;
            OFS_ALT_DAMP: next_st.rdata[15:0] = st.regs.alt.damping;
            OFS_STATUS: begin
               next_st.rdata[STAT_ACT_BIT] = st.active;
               next_st.rdata[STAT_RATIO_LSB +: 7] = st.ratio;
            end
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign rdata = st.rdata;
   assign applied = st.applied;
   assign switch_active = st.active;

endmodule : gss_select

// ### verification/gss_host.sv
`timescale 1ns/10ps
module gss_host (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Requests from the bench
   input wire logic want_switch,
   input wire logic at_rest,
   // Pin toward the amplifier
   output logic gain_switch_input
);
   // Pin follows the request only while the motor stands still
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gain_switch_input <= 1'b0;
      end else if (at_rest) begin
         gain_switch_input <= want_switch;
      end
   end
endmodule : gss_host

// ### verification/gss_select_assertions.sv
`timescale 1ns/10ps
module gss_select_assertions
   import gss_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [31:0] rdata,
   // Switching and results
   input wire logic gain_switch_input,
   input wire logic [15:0] monitor_value,
   input wire gss_gains_t applied,
   input wire logic switch_active
);
   logic [3:0] sel_s;
   logic dir_s;
   logic [15:0] thr_s;
   // Shadow of switch source, direction and threshold
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sel_s <= 4'h0;
         dir_s <= 1'b0;
         thr_s <= 16'h0000;
      end else if (wr_stb && addr == OFS_MODE) begin
         sel_s <= wdata[SEL_LSB +: 4];
         dir_s <= wdata[DIR_BIT];
      end else if (wr_stb && addr == OFS_THRESH) begin
         thr_s <= wdata[15:0];
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // Read back of a setting never exceeds its limit
   property clip_p(logic [7:0] ofs, logic [15:0] lim);
      rd_stb && addr == ofs |=> rdata <= 32'(lim);
   endproperty
   src_off_a: assert property (
      (sel_s == SEL_OFF || sel_s > SEL_LAST)[*3] |-> !switch_active)
      else $error("switch active with source off");
   pin_rise_a: assert property (
      $rose(gain_switch_input) && sel_s == SEL_INPUT |-> ##[1:4] switch_active)
      else $error("pin rise not followed");
   pin_fall_a: assert property (
      $fell(gain_switch_input) && sel_s == SEL_INPUT
      |-> ##[1:4] !switch_active)
      else $error("pin fall not followed");
   cmp_ge_a: assert property (
      (sel_s inside {[4'h2:SEL_LAST]} && !dir_s && monitor_value >= thr_s)[*3]
      |-> switch_active) else $error("at or above compare missed");
   cmp_le_a: assert property (
      (sel_s inside {[4'h2:SEL_LAST]} && dir_s && monitor_value <= thr_s)[*3]
      |-> switch_active) else $error("at or below compare missed");
   pos_clip_a: assert property (clip_p(OFS_ALT_POS, POS_MAX))
      else $error("position gain above limit");
   vib_clip_a: assert property (clip_p(OFS_ALT_VIB, FREQ_MAX))
      else $error("vibration frequency above limit");
   damp_clip_a: assert property (clip_p(OFS_ALT_DAMP, DAMP_MAX))
      else $error("damping above limit");
   tc_clip_a: assert property (clip_p(OFS_TCONST, TC_MAX))
      else $error("time constant above limit");
   // Main scenarios
   cover property ($rose(switch_active));
   cover property ($fell(switch_active));
   cover property (sel_s == 4'h4 && dir_s && switch_active);
endmodule : gss_select_assertions
bind gss_select gss_select_assertions u_chk (.sys_clk, .resetn, .addr,
   .wdata, .wr_stb, .rd_stb, .rdata, .gain_switch_input, .monitor_value,
   .applied, .switch_active);

// ### verification/gss_select_tb.sv
`timescale 1ns/10ps
module gss_select_tb;
   import gss_pkg::*;
   logic sys_clk = 0, resetn = 0, wr_stb = 0, rd_stb = 0;
   logic want = 0, rest = 1, gsi, active;
   logic [7:0] addr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [15:0] mon = 0;
   logic [15:0] bv [6] = '{16'h0100, 16'h0040, 16'h0020, 16'h0050,
      16'h0060, 16'h0005};
   logic [15:0] av [6] = '{16'h0200, 16'h0080, 16'h0030, 16'h0070,
      16'h0090, 16'h0010};
   gss_gains_t applied;
   int num_errors = 0, checked = 0;
   gss_select #(.STEP_CYCLES(2)) u_dut (.sys_clk, .resetn, .addr, .wdata,
      .wr_stb, .rd_stb, .rdata, .gain_switch_input(gsi),
      .monitor_value(mon), .applied, .switch_active(active));
   gss_host u_host (.sys_clk, .resetn, .want_switch(want), .at_rest(rest),
      .gain_switch_input(gsi));
   initial forever #10 sys_clk = ~sys_clk;
   function automatic logic [31:0] mode_word(logic [3:0] a, t, s, logic d);
      return {19'h0, d, s, t, a};
   endfunction : mode_word
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Bus cycles
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask : wr
   task automatic rd(string n, logic [7:0] a, logic [31:0] e);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      @(negedge sys_clk);
      chk(n, e, rdata);
   endtask : rd
   task automatic load(logic [31:0] m);
      wr(OFS_MODE, m);
      wr(OFS_TCONST, 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr(8'h0c + 8'(8 * i), 32'(bv[i]));
         wr(8'h10 + 8'(8 * i), 32'(av[i]));
      end
   endtask : load
   task automatic flip(logic v);
      int n = 0;
      @(posedge sys_clk);
      want <= v;
      while (active !== v && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      chk("active", 32'(v), 32'(active));
      repeat (4) @(negedge sys_clk);
   endtask : flip
   task automatic expect_set(logic [5:0] m);
      logic [15:0] e;
      for (int i = 0; i < 6; i++) begin
         e = m[5-i] ? av[i] : bv[i];
         chk("applied", 32'(e), 32'(applied[80-16*i +: 16]));
      end
   endtask : expect_set
   task automatic t_clip();
      logic [7:0] o [6] = '{OFS_ALT_POS, OFS_ALT_INT, OFS_ALT_VIB,
         OFS_ALT_RES, OFS_ALT_DAMP, OFS_TCONST};
      logic [15:0] l [6] = '{POS_MAX, INT_MAX, FREQ_MAX, FREQ_MAX,
         DAMP_MAX, TC_MAX};
      for (int i = 0; i < 6; i++) begin
         wr(o[i], 32'h0001_0000);
         rd("clipped", o[i], 32'(l[i]));
      end
      wr(OFS_ALT_SPD, 32'h0000_ffff);
      rd("speed", OFS_ALT_SPD, 32'h0000_ffff);
      rd("unmapped", 8'h40, 32'h0);
      $display("clip test done");
   endtask : t_clip
   task automatic t_pin();
      logic [31:0] m;
      m = mode_word(ADJ_MANUAL, TUNE_MANUAL, SEL_INPUT, 1'b0);
      load(m);
      rd("mode", OFS_MODE, m);
      @(posedge sys_clk);
      rest <= 1'b0;
      want <= 1'b1;
      repeat (8) @(negedge sys_clk);
      chk("held", 32'h0, 32'(active));
      @(posedge sys_clk);
      rest <= 1'b1;
      flip(1'b1);
      expect_set(6'h3f);
      rd("status", OFS_STATUS, 32'({RAMP_FULL, 7'h00, 1'b1}));
      flip(1'b0);
      expect_set(6'h00);
      rd("status idle", OFS_STATUS, 32'h0);
      $display("pin test done");
   endtask : t_pin
   task automatic t_gate();
      logic [31:0] md [2] = '{mode_word(ADJ_MANUAL, 4'h0, SEL_INPUT, 1'b0),
         mode_word(4'h0, TUNE_MANUAL, SEL_INPUT, 1'b0)};
      logic [5:0] mk [2] = '{6'h38, 6'h00};
      for (int i = 0; i < 2; i++) begin
         load(md[i]);
         flip(1'b1);
         expect_set(mk[i]);
         flip(1'b0);
      end
      $display("gate test done");
   endtask : t_gate
   task automatic t_ramp();
      int n = 0;
      load(mode_word(ADJ_MANUAL, TUNE_MANUAL, SEL_INPUT, 1'b0));
      wr(OFS_TCONST, 32'h1);
      flip(1'b1);
      chk("mid", 32'h1, 32'(applied.pos_gain > bv[0]));
      while (applied.pos_gain !== av[0] && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      chk("ramp", 32'h1, 32'(n > 180 && n < 210));
      flip(1'b0);
      repeat (220) @(negedge sys_clk);
      expect_set(6'h00);
      $display("ramp test done");
   endtask : t_ramp
   task automatic t_mon();
      logic [15:0] mv [3] = '{16'h00ff, 16'h0100, 16'h0101};
      wr(OFS_THRESH, 32'h0000_0100);
      for (int s = 2; s <= 4; s++) begin
         for (int d = 0; d < 2; d++) begin
            wr(OFS_MODE, mode_word(ADJ_MANUAL, TUNE_MANUAL, 4'(s), d[0]));
            for (int k = 0; k < 3; k++) begin
               @(posedge sys_clk);
               mon <= mv[k];
               repeat (3) @(negedge sys_clk);
               chk("compare", 32'(d ? k < 2 : k > 0), 32'(active));
            end
         end
      end
      $display("monitor test done");
   endtask : t_mon
   task automatic t_floor();
      av = '{POS_MIN, SPD_MIN - 16'h1, 16'h0, FREQ_MIN, 16'h0, 16'h0};
      load(mode_word(ADJ_MANUAL, TUNE_MANUAL, SEL_INPUT, 1'b0));
      flip(1'b1);
      expect_set(6'b100101);
      flip(1'b0);
      $display("floor test done");
   endtask : t_floor
   task automatic t_reset();
      flip(1'b1);
      @(posedge sys_clk);
      resetn <= 1'b0;
      want <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      @(negedge sys_clk);
      chk("reset active", 32'h0, 32'(active));
      chk("reset applied", 32'h0, 32'(applied !== 96'h0));
      rd("reset mode", OFS_MODE, 32'h0);
      $display("reset test done");
   endtask : t_reset
   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      @(negedge sys_clk);
      chk("reset", 32'h0, 32'(applied !== 96'h0));
      t_clip();
      t_pin();
      t_gate();
      t_ramp();
      t_mon();
      t_floor();
      t_reset();
      conclude();
   end
   // Watchdog
   initial begin
      repeat (8000) @(posedge sys_clk);
      num_errors++;
      conclude();
   end
endmodule : gss_select_tb
